// file: core/fptl_pkg.sv
// Purpose: Shared constants and the normalising pack function of the
//          integer-part and base-10 logarithm execution slice.
// Assumes: Extended values are 80 bits: sign, 15-bit exponent, 64-bit
//          mantissa with an explicit integer bit.
// Notes:   Register offsets are byte addresses on the APB side.
package fptl_pkg;
	// Register byte offsets.
	localparam logic [7:0] A_OPWORD = 8'h00;
	localparam logic [7:0] A_CMD = 8'h04;
	localparam logic [7:0] A_OPND0 = 8'h08;
	localparam logic [7:0] A_OPND1 = 8'h0C;
	localparam logic [7:0] A_OPND2 = 8'h10;
	localparam logic [7:0] A_STATUS = 8'h14;
	localparam logic [7:0] A_IRQ_ST = 8'h18;
	localparam logic [7:0] A_IRQ_MASK = 8'h1C;
	localparam logic [7:0] A_CPID = 8'h20;
	localparam logic [7:0] A_REG_SEL = 8'h24;
	localparam logic [7:0] A_REG_LO = 8'h28;
	localparam logic [7:0] A_REG_MID = 8'h2C;
	localparam logic [7:0] A_REG_HI = 8'h30;
	// Reset value of the own coprocessor identifier.
	localparam logic [2:0] CPID_RST = 3'h1;
	// Source formats when the operand comes from memory.
	localparam logic [2:0] FMT_L = 3'h0;
	localparam logic [2:0] FMT_S = 3'h1;
	localparam logic [2:0] FMT_X = 3'h2;
	localparam logic [2:0] FMT_P = 3'h3;
	localparam logic [2:0] FMT_W = 3'h4;
	localparam logic [2:0] FMT_D = 3'h5;
	localparam logic [2:0] FMT_B = 3'h6;
	localparam logic [2:0] FMT_BAD = 3'h7;
	// Operation codes in the low seven bits of the command word.
	localparam logic [6:0] OP_INTRZ = 7'h03;
	localparam logic [6:0] OP_LOG10 = 7'h15;
	// Extended-format constants.
	localparam int EXP_BIAS = 16383;
	localparam logic [14:0] EXP_MAX = 15'h7FFF;
	localparam logic [79:0] QNAN_DEF = 80'h7FFF_FFFF_FFFF_FFFF_FFFF;
	localparam logic [79:0] NEG_INF = 80'hFFFF_8000_0000_0000_0000;
	// Base-10 logarithm of two with 32 fraction bits.
	localparam logic [31:0] LOG10_2_Q32 = 32'h4D10_4D42;
	// Exception byte bit positions.
	localparam int EXC_SIGNALING_NAN_FLAG = 6;
	localparam int EXC_OPERAND_ERROR_FLAG = 5;
	localparam int EXC_DZ = 2;
	localparam int EXC_INEXACT_OPERATION_FLAG = 1;
	localparam int EXC_INEXACT_DECIMAL_INPUT_FLAG = 0;
	// Status register field positions.
	localparam int ST_BUSY = 7;
	localparam int ST_ILL = 6;
	// Interrupt status bits.
	localparam int IRQ_DONE = 0;
	localparam int IRQ_OPERAND_ERROR_FLAG = 1;
	localparam int IRQ_DZ = 2;
	localparam int IRQ_SIGNALING_NAN_FLAG = 3;
	localparam int IRQ_INEX = 4;
	localparam int IRQ_ILL = 5;
	localparam int IRQ_W = 6;
	// Effective-address classes reported in the status register.
	localparam logic [3:0] EA_NONE = 4'h0;
	localparam logic [3:0] EA_DREG = 4'h1;
	localparam logic [3:0] EA_IND = 4'h2;
	localparam logic [3:0] EA_POSTINC = 4'h3;
	localparam logic [3:0] EA_PREDEC = 4'h4;
	localparam logic [3:0] EA_DISP = 4'h5;
	localparam logic [3:0] EA_INDEX = 4'h6;
	localparam logic [3:0] EA_ABS_W = 4'h7;
	localparam logic [3:0] EA_ABS_L = 4'h8;
	localparam logic [3:0] EA_IMM = 4'h9;
	localparam logic [3:0] EA_PC_DISP = 4'hA;
	localparam logic [3:0] EA_PC_INDEX = 4'hB;
	localparam logic [3:0] EA_BAD = 4'hF;

	// Normalises mag * 2**e_lsb into extended; bit 80 flags lost bits.
	function automatic logic [80:0] fptl_pack(input logic s,
		input logic [127:0] mag, input int e_lsb);
		int msb;
		logic [127:0] sh;
		msb = -1;
		sh = '0;
		for (int i = 0; i < 128; i++) begin
			if (mag[i]) begin
				msb = i;
			end
		end
		if (msb < 0) begin
			return {1'b0, s, 79'h0};
		end
		sh = mag << (127 - msb);
		return {|sh[63:0], s, 15'(EXP_BIAS + msb + e_lsb), sh[127:64]};
	endfunction
endpackage

// file: core/fptl_to_ext.sv
// Purpose: Converts a memory operand of any source format to extended.
// Assumes: The operand sits right-aligned in a 96-bit word.
// Notes:   Packed input yields the digit integer and a power-of-ten
//          scale that the caller applies step by step.
`timescale 1ns/100ps
module fptl_to_ext (
	input wire logic [2:0] fmt,
	input wire logic [95:0] raw,
	output logic [79:0] ext,
	output logic signed [11:0] scale
);
	import fptl_pkg::*;

	logic [31:0] iv;
	logic [31:0] mag;
	logic [63:0] n;
	logic [11:0] pexp;
	logic [3:0] d;
	logic [80:0] r;

	// Format decode and widening to extended precision.
	always_comb begin
		iv = '0;
		mag = '0;
		n = '0;
		pexp = '0;
		d = '0;
		r = '0;
		scale = 12'sh0;
		unique case (fmt)
			FMT_B, FMT_W, FMT_L: begin
				if (fmt == FMT_B) begin
					iv = {{24{raw[7]}}, raw[7:0]};
				end else if (fmt == FMT_W) begin
					iv = {{16{raw[15]}}, raw[15:0]};
				end else begin
					iv = raw[31:0];
				end
				mag = iv[31] ? 32'(-iv) : iv;
				r = fptl_pack(iv[31], {96'h0, mag}, 0);
			end
			FMT_S: begin
				if (raw[30:23] == 8'hFF) begin
					r = {1'b0, raw[31], EXP_MAX, 1'b1, raw[22:0], 40'h0};
				end else if (raw[30:23] == 8'h00) begin
					r = fptl_pack(raw[31], {105'h0, raw[22:0]}, -149);
				end else begin
					r = fptl_pack(raw[31], {104'h0, 1'b1, raw[22:0]},
						int'(raw[30:23]) - 150);
				end
			end
			FMT_D: begin
				if (raw[62:52] == 11'h7FF) begin
					r = {1'b0, raw[63], EXP_MAX, 1'b1, raw[51:0], 11'h0};
				end else if (raw[62:52] == 11'h000) begin
					r = fptl_pack(raw[63], {76'h0, raw[51:0]}, -1074);
				end else begin
					r = fptl_pack(raw[63], {75'h0, 1'b1, raw[51:0]},
						int'(raw[62:52]) - 1075);
				end
			end
			FMT_X: begin
				r = {1'b0, raw[95:80], raw[63:0]};
			end
			FMT_P: begin
				// Seventeen digits: integer digit first, then fraction.
				for (int i = 16; i >= 0; i--) begin
					d = raw[4*i +: 4];
					n = 64'(n * 64'd10) + {60'h0, d};
				end
				for (int i = 2; i >= 0; i--) begin
					d = raw[80 + 4*i +: 4];
					pexp = 12'(pexp * 12'd10) + {8'h0, d};
				end
				r = fptl_pack(raw[95], {64'h0, n}, 0);
				scale = (raw[94] ? -$signed(pexp) : $signed(pexp))
					- 12'sd16;
			end
			default: begin
				r = '0;
			end
		endcase
		ext = r[79:0];
	end
endmodule

// file: core/fptl_unit.sv
// Purpose: Integer-part truncate and base-10 logarithm execution slice
//          with operation word decoding, behind an APB register file.
// Assumes: The main processor places the operand words and both
//          instruction words into registers, command word last.
// Notes:   The command word write launches the operation.
// Behaviour
// - Truncate widens source, then rounds toward zero regardless of rounding mode.
// - Truncate result is an extended float written to the destination register.
// - Truncate keeps signed zero and signed infinity unchanged.
// - Only operation words carrying our coprocessor identifier are executed.
// - Source mode bit: 0 register source, 1 memory operand.
// - Register source: specifier names the source data register.
// - Memory source: specifier gives long, single, extended, packed, word, double, byte.
// - Equal source and destination registers read and write the same register.
// - Data register direct only for byte, word, long, single; address direct refused.
// - Mode 111 register subfield picks absolute, immediate or PC-relative forms.
// - All seven source formats are widened to extended before computing.
// - Logarithm gives base-10 log of positive values; plus infinity stays.
// - Negative source to the logarithm gives NaN and operand error.
// - Zero source to the logarithm gives minus infinity and divide by zero.
`timescale 1ns/100ps
module fptl_unit #(
	parameter int LOG_BITS = 32
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq
);
	import fptl_pkg::*;

	// The log iteration counter and fixed-point widths limit the range.
	if (LOG_BITS < 8 || LOG_BITS > 40) begin : g_chk
		$error("LOG_BITS must lie between 8 and 40");
	end

	typedef enum logic [2:0] {
		S_IDLE, S_SCALE, S_EXEC, S_LOG, S_FIN
	} fptl_state_t;

	typedef struct packed {
		fptl_state_t st;
		logic [7:0][79:0] fpr;
		logic [79:0] w;
		logic [15:0] opw;
		logic [2:0] cpid;
		logic [2:0] sel;
		logic [2:0] dst;
		logic [2:0][31:0] opnd;
		logic [7:0] quot;
		logic [7:0] exc;
		logic ill;
		logic [3:0] eac;
		logic [IRQ_W-1:0] ist;
		logic [IRQ_W-1:0] imask;
		logic islog;
		logic inexact_decimal_input_flag;
		logic signed [11:0] scale;
		logic [5:0] cnt;
		logic [63:0] lm;
		logic signed [15:0] le;
		logic [LOG_BITS-1:0] lf;
		logic [31:0] rdata;
	} fptl_regs_t;

	fptl_regs_t r_q, r_d;
	logic setup, acc, wr, rd, hit, own, okop, legal, launch;
	logic s, isinf, isnan, iszero, fin;
	logic [15:0] cmd;
	logic [3:0] ea;
	logic [79:0] cv_ext, res;
	logic signed [11:0] cv_scale;
	logic [80:0] pk;
	logic [127:0] prod, quo;
	logic [7:0] exc_n;
	logic [IRQ_W-1:0] iset, iclr;
	logic signed [LOG_BITS+15:0] lv;
	logic [LOG_BITS+15:0] lmag;
	logic [63:0] keep;
	int e;

	// Classifies the addressing mode; illegal combinations give EA_BAD.
	function automatic logic [3:0] ea_class(input logic [2:0] mode,
		input logic [2:0] rg, input logic [2:0] fmt);
		unique case (mode)
			3'h0: return (fmt == FMT_B || fmt == FMT_W || fmt == FMT_L ||
				fmt == FMT_S) ? EA_DREG : EA_BAD;
			3'h1: return EA_BAD;
			3'h2: return EA_IND;
			3'h3: return EA_POSTINC;
			3'h4: return EA_PREDEC;
			3'h5: return EA_DISP;
			3'h6: return EA_INDEX;
			3'h7: begin
				unique case (rg)
					3'h0: return EA_ABS_W;
					3'h1: return EA_ABS_L;
					3'h2: return EA_PC_DISP;
					3'h3: return EA_PC_INDEX;
					3'h4: return EA_IMM;
					default: return EA_BAD;
				endcase
			end
		endcase
	endfunction

	fptl_to_ext u_conv (
		.fmt(pwdata[12:10]),
		.raw(r_q.opnd),
		.ext(cv_ext),
		.scale(cv_scale)
	);

	// APB phases; zero wait states, read data captured in setup.
	assign setup = psel & ~penable;
	assign acc = psel & penable;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;
	assign hit = (paddr[1:0] == 2'h0) && (paddr <= A_REG_HI);
	assign pready = 1'b1;
	assign pslverr = acc & ~hit;
	assign prdata = r_q.rdata;
	assign irq = |(r_q.ist & r_q.imask);

	// Instruction decode of the stored operation word and the command.
	assign cmd = pwdata[15:0];
	assign own = (r_q.opw[15:12] == 4'hF) && (r_q.opw[8:6] == 3'h0) &&
		(r_q.opw[11:9] == r_q.cpid);
	assign okop = !cmd[15] && !cmd[13] &&
		(cmd[6:0] == OP_INTRZ || cmd[6:0] == OP_LOG10);
	// With register source the address field is not looked at.
	assign ea = cmd[14] ? ea_class(r_q.opw[5:3], r_q.opw[2:0],
		cmd[12:10]) : EA_NONE;
	assign legal = okop && ea != EA_BAD &&
		!(cmd[14] && cmd[12:10] == FMT_BAD);
	assign launch = wr && paddr == A_CMD && r_q.st == S_IDLE && own;

	// Operand classification of the working value.
	assign s = r_q.w[79];
	assign isinf = r_q.w[78:64] == EXP_MAX && r_q.w[62:0] == 63'h0;
	assign isnan = r_q.w[78:64] == EXP_MAX && r_q.w[62:0] != 63'h0;
	assign iszero = r_q.w[78:64] != EXP_MAX && r_q.w[63:0] == 64'h0;

	// Next-state logic of the whole block.
	always_comb begin
		r_d = r_q;
		iset = '0;
		iclr = '0;
		fin = 1'b0;
		res = r_q.w;
		exc_n = '0;
		pk = '0;
		prod = '0;
		quo = '0;
		lv = '0;
		lmag = '0;
		keep = '0;
		e = 0;
		// Read data for the access phase that follows.
		if (setup) begin
			unique case (paddr)
				A_OPWORD: r_d.rdata = {16'h0, r_q.opw};
				A_OPND0: r_d.rdata = r_q.opnd[0];
				A_OPND1: r_d.rdata = r_q.opnd[1];
				A_OPND2: r_d.rdata = r_q.opnd[2];
				A_STATUS: r_d.rdata = {8'h0, r_q.quot, r_q.exc,
					r_q.st != S_IDLE, r_q.ill, 2'h0, r_q.eac};
				A_IRQ_ST: r_d.rdata = {26'h0, r_q.ist};
				A_IRQ_MASK: r_d.rdata = {26'h0, r_q.imask};
				A_CPID: r_d.rdata = {29'h0, r_q.cpid};
				A_REG_SEL: r_d.rdata = {29'h0, r_q.sel};
				A_REG_LO: r_d.rdata = r_q.fpr[r_q.sel][31:0];
				A_REG_MID: r_d.rdata = r_q.fpr[r_q.sel][63:32];
				A_REG_HI: r_d.rdata = {16'h0, r_q.fpr[r_q.sel][79:64]};
				default: r_d.rdata = 32'h0;
			endcase
		end
		// Reading the interrupt status clears the bits it returned.
		if (rd && paddr == A_IRQ_ST) begin
			iclr = r_q.rdata[IRQ_W-1:0];
		end
		// Register writes.
		if (wr) begin
			unique case (paddr)
				A_OPWORD: r_d.opw = pwdata[15:0];
				A_OPND0: r_d.opnd[0] = pwdata;
				A_OPND1: r_d.opnd[1] = pwdata;
				A_OPND2: r_d.opnd[2] = pwdata;
				A_STATUS: {r_d.quot, r_d.exc} = pwdata[23:8];
				A_IRQ_MASK: r_d.imask = pwdata[IRQ_W-1:0];
				A_CPID: r_d.cpid = pwdata[2:0];
				A_REG_SEL: r_d.sel = pwdata[2:0];
				A_REG_LO: r_d.fpr[r_q.sel][31:0] = pwdata;
				A_REG_MID: r_d.fpr[r_q.sel][63:32] = pwdata;
				A_REG_HI: r_d.fpr[r_q.sel][79:64] = pwdata[15:0];
				default: r_d.rdata = r_d.rdata;
			endcase
		end
		// Operation sequencer.
		unique case (r_q.st)
			S_IDLE: begin
				if (launch) begin
					r_d.ill = !legal;
					r_d.eac = ea;
					if (!legal) begin
						iset[IRQ_ILL] = 1'b1;
					end else begin
						// Register or converted memory source.
						r_d.w = cmd[14] ? cv_ext
							: r_q.fpr[cmd[12:10]];
						r_d.dst = cmd[9:7];
						r_d.islog = cmd[6:0] == OP_LOG10;
						r_d.inexact_decimal_input_flag = 1'b0;
						r_d.scale = (cmd[14] && cmd[12:10] == FMT_P)
							? cv_scale : 12'sh0;
						r_d.st = (r_d.scale != 12'sh0) ? S_SCALE : S_EXEC;
					end
				end
			end
			S_SCALE: begin
				// One power of ten per cycle for packed decimal input.
				e = int'(r_q.w[78:64]) - EXP_BIAS - 63;
				if (r_q.scale > 12'sh0) begin
					prod = {64'h0, r_q.w[63:0]} * 128'd10;
					pk = fptl_pack(s, prod, e);
					r_d.scale = r_q.scale - 12'sd1;
				end else begin
					quo = {r_q.w[63:0], 64'h0} / 128'd10;
					prod = quo * 128'd10;
					if (prod != {r_q.w[63:0], 64'h0}) begin
						r_d.inexact_decimal_input_flag = 1'b1;
					end
					pk = fptl_pack(s, quo, e - 64);
					r_d.scale = r_q.scale + 12'sd1;
				end
				r_d.w = pk[79:0];
				if (r_d.scale == 12'sh0) begin
					r_d.st = S_EXEC;
				end
			end
			S_EXEC: begin
				fin = 1'b1;
				e = int'(r_q.w[78:64]) - EXP_BIAS;
				if (isnan) begin
					res = {r_q.w[79:63], 1'b1, r_q.w[61:0]};
					exc_n[EXC_SIGNALING_NAN_FLAG] = !r_q.w[62];
				end else if (!r_q.islog) begin
					if (iszero || isinf) begin
						res = iszero ? {s, 79'h0} : r_q.w;
					end else if (e < 0) begin
						res = {s, 79'h0};
						exc_n[EXC_INEXACT_OPERATION_FLAG] = 1'b1;
					end else if (e < 63) begin
						keep = 64'hFFFF_FFFF_FFFF_FFFF << (63 - e);
						res = {r_q.w[79:64], r_q.w[63:0] & keep};
						exc_n[EXC_INEXACT_OPERATION_FLAG] = |(r_q.w[63:0] & ~keep);
					end
				end else if (iszero) begin
					res = NEG_INF;
					exc_n[EXC_DZ] = 1'b1;
				end else if (s) begin
					res = QNAN_DEF;
					exc_n[EXC_OPERAND_ERROR_FLAG] = 1'b1;
				end else if (isinf) begin
					res = r_q.w;
				end else begin
					// Normalise, then iterate the binary logarithm.
					fin = 1'b0;
					e = (r_q.w[78:64] == 15'h0) ? 1 - EXP_BIAS : e;
					pk = fptl_pack(1'b0, {64'h0, r_q.w[63:0]}, e - 63);
					r_d.lm = pk[63:0];
					r_d.le = 16'(int'(pk[78:64]) - EXP_BIAS);
					r_d.lf = '0;
					r_d.cnt = '0;
					r_d.st = S_LOG;
				end
			end
			S_LOG: begin
				// Squaring yields one fraction bit of log2 per cycle.
				prod = {64'h0, r_q.lm} * {64'h0, r_q.lm};
				r_d.lf = {r_q.lf[LOG_BITS-2:0], prod[127]};
				r_d.lm = prod[127] ? prod[127:64] : prod[126:63];
				r_d.cnt = r_q.cnt + 6'h1;
				if (r_q.cnt == 6'(LOG_BITS - 1)) begin
					r_d.st = S_FIN;
				end
			end
			S_FIN: begin
				// Scale log2 by log10(2) and round toward zero.
				fin = 1'b1;
				lv = {r_q.le, r_q.lf};
				lmag = lv[LOG_BITS+15] ? (LOG_BITS+16)'(-lv) : lv;
				prod = 128'(lmag) * 128'(LOG10_2_Q32);
				pk = fptl_pack(lv[LOG_BITS+15], prod, -(LOG_BITS + 32));
				res = pk[79:0];
				exc_n[EXC_INEXACT_OPERATION_FLAG] = lmag != '0;
			end
		endcase
		// Completion writes the destination, the exception byte and the interrupt status; the quotient byte is kept.
		if (fin) begin
			exc_n[EXC_INEXACT_DECIMAL_INPUT_FLAG] = r_q.inexact_decimal_input_flag;
			r_d.fpr[r_q.dst] = res;
			r_d.exc = exc_n;
			r_d.st = S_IDLE;
			iset[IRQ_DONE] = 1'b1;
			iset[IRQ_OPERAND_ERROR_FLAG] = exc_n[EXC_OPERAND_ERROR_FLAG];
			iset[IRQ_DZ] = exc_n[EXC_DZ];
			iset[IRQ_SIGNALING_NAN_FLAG] = exc_n[EXC_SIGNALING_NAN_FLAG];
			iset[IRQ_INEX] = exc_n[EXC_INEXACT_OPERATION_FLAG] | exc_n[EXC_INEXACT_DECIMAL_INPUT_FLAG];
		end
		// A new event wins over a clear by read in the same cycle.
		r_d.ist = (r_q.ist & ~iclr) | iset;
		if (!resetn) begin
			r_d = '0;
			r_d.cpid = CPID_RST;
		end
	end

	// State register.
	always_ff @(posedge clk_sys) begin
		r_q <= r_d;
	end
endmodule

// file: testbench/fptl_unit_sva.sv
// Purpose: Port-level checks of the truncate and log10 execution slice.
// Assumes: APB slave without wait states; reset is synchronous.
// Notes:   Sees only the ports of the top module.
`timescale 1ns/100ps
module fptl_unit_chk
import fptl_pkg::*;
#(
	parameter int LOG_BITS = 32
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq
);
	logic acc;
	logic rd;
	logic bad;
	logic quo_v_q;
	logic sw_q;
	logic [7:0] quo_q;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	// Decodes of the current bus cycle.
	assign acc = psel && penable;
	assign rd = acc && !pwrite;
	assign bad = paddr[1:0] != 2'h0 || paddr > A_REG_HI;
	// Remembers the last quotient byte read and any write to status.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			quo_v_q <= 1'b0;
			sw_q <= 1'b0;
			quo_q <= 8'h00;
		end else if (acc && paddr == A_STATUS) begin
			quo_v_q <= !pwrite;
			sw_q <= sw_q || pwrite;
			quo_q <= prdata[23:16];
		end
	end
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence rd_stat_s;
		rd && paddr == A_STATUS;
	endsequence
	pready_high_a: assert property (pready)
		else $error("pready low");
	unmapped_err_a: assert property (acc && bad |-> pslverr)
		else $error("no error on unmapped access");
	mapped_ok_a: assert property (acc && !bad |-> !pslverr)
		else $error("error on mapped access");
	read_hold_a: assert property (setup_s ##1 rd |=> $stable(prdata))
		else $error("read data moved after access");
	cmd_reads_zero_a: assert property (rd && paddr == A_CMD |-> prdata == 0)
		else $error("command word readable");
	irq_fall_a: assert property ($fell(irq) |-> !$past(resetn) ||
		$past(rd && paddr == A_IRQ_ST) ||
		$past(acc && pwrite && paddr == A_IRQ_MASK))
		else $error("interrupt dropped without cause");
	quotient_keep_a: assert property (
		rd_stat_s ##0 quo_v_q |-> prdata[23:16] == quo_q)
		else $error("quotient byte changed");
	exc_clear_a: assert property (
		rd_stat_s ##0 !sw_q |-> prdata[15] == 1'b0 && prdata[12:11] == 2'h0)
		else $error("unused exception flag set");
	irq_width_a: assert property (rd && paddr == A_IRQ_ST |->
		prdata[31:IRQ_W] == '0)
		else $error("undefined interrupt bit set");
endmodule
bind fptl_unit fptl_unit_chk #(.LOG_BITS(LOG_BITS)) u_chk (.clk_sys,
	.resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
	.pslverr, .irq);

// file: testbench/fptl_host.sv
// Purpose: Main processor model issuing coprocessor work over APB.
// Assumes: The slave answers through pready.
// Notes:   Released write data is inverted so stale values never match.
`timescale 1ns/100ps
module fptl_host
import fptl_pkg::*;
(
	input wire logic clk_sys,
	output logic [7:0] paddr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// Idle bus at time zero.
	initial begin
		paddr = 8'h00;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0;
	end
	// One transfer: setup, then access held until pready is sampled high.
	task automatic xfer(input logic w, input logic [7:0] a,
		inout logic [31:0] d, output logic e);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		if (!w) d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask
	// Sends both instruction words, the command word last.
	task automatic issue(input logic [2:0] id, input logic [5:0] ea,
		input logic rm, input logic [2:0] sp, input logic [2:0] dst,
		input logic [6:0] op);
		logic [31:0] d;
		logic e;
		d = {16'h0, 4'hF, id, 3'h0, rm ? ea : 6'h0};
		xfer(1'b1, A_OPWORD, d, e);
		d = {16'h0, 1'b0, rm, 1'b0, sp, dst, op};
		xfer(1'b1, A_CMD, d, e);
	endtask
endmodule

// file: testbench/fp_trunc_int_and_log10_unit_bench.sv
// Purpose: Self-checking bench of the truncate and log10 slice.
// Assumes: Host model drives APB; log2 uses 16 fraction bits.
// Notes:   Expected values are worked out by hand from the formats.
`timescale 1ns/100ps
module fp_trunc_int_and_log10_unit_bench import fptl_pkg::*;;
	localparam logic [63:0] K = 64'h8000_0000_0000_0000;
	localparam logic [79:0] P123 = {16'h4005, 64'hF600_0000_0000_0000};
	localparam logic [79:0] SRC [11] = '{{16'h8000, 64'h0},
		{16'h7FFF, K}, {16'hFFFF, K}, {16'h7FFF, K | 64'h4000_0000_0000_0005},
		{16'h7FFF, K | 64'h1}, {16'h7FFF, K}, {16'hC001, 64'hA << 60},
		{16'hFFFF, K}, 80'h0, {16'h8000, 64'h0}, {16'h3FFF, K}};
	localparam logic [79:0] RES [11] = '{SRC[0], SRC[1], SRC[2], SRC[3],
		{16'h7FFF, K | 64'h4000_0000_0000_0001}, SRC[5], QNAN_DEF, QNAN_DEF,
		NEG_INF, NEG_INF, 80'h0};
	localparam logic [7:0] EXC [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40,
		8'h00, 8'h20, 8'h20, 8'h04, 8'h04, 8'h00};
	localparam logic [95:0] MEM [7] = '{96'hFFFF_FF85, 96'h42F6_0000,
		{32'h4005_0000, 32'hF600_0000, 32'h0}, {32'h0002_0001, 32'h2300_0000,
		32'h0}, 96'h7B, {32'h0, 32'h405E_C000, 32'h0}, 96'h85};
	localparam logic [3:0] CLS [5] = '{EA_ABS_W, EA_ABS_L, EA_PC_DISP,
		EA_PC_INDEX, EA_IMM};
	logic clk_sys;
	logic resetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic pready;
	logic pslverr;
	logic irq;
	logic e;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] d;
	logic [79:0] v;
	int error_cnt = 0;
	int n_checks = 0;
	fptl_unit #(.LOG_BITS(16)) dut (.clk_sys(clk_sys), .resetn(resetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq));
	fptl_host host (.clk_sys(clk_sys), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	// 40 MHz clock.
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic close_out;
		if (error_cnt == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [79:0] x,
		input logic [79:0] g);
		n_checks++;
		if (g !== x) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] w);
		host.xfer(1'b1, a, w, e);
	endtask
	task automatic rd(input logic [7:0] a);
		d = 32'h0;
		host.xfer(1'b0, a, d, e);
	endtask
	task automatic rchk(input string n, input logic [7:0] a,
		input logic [31:0] x, input logic [31:0] m);
		rd(a);
		chk(n, {48'h0, x}, {48'h0, d & m});
	endtask
	task automatic setfp(input logic [2:0] r, input logic [79:0] x);
		wr(A_REG_SEL, {29'h0, r});
		wr(A_REG_LO, x[31:0]);
		wr(A_REG_MID, x[63:32]);
		wr(A_REG_HI, {16'h0, x[79:64]});
	endtask
	task automatic fpchk(input string n, input logic [2:0] r,
		input logic [79:0] x);
		wr(A_REG_SEL, {29'h0, r});
		rd(A_REG_LO);
		v[31:0] = d;
		rd(A_REG_MID);
		v[63:32] = d;
		rd(A_REG_HI);
		v[79:64] = d[15:0];
		chk(n, x, v);
	endtask
	// Issues with our own identifier and polls busy; leaves status in d.
	task automatic run(input logic [5:0] ea, input logic rm,
		input logic [2:0] sp, input logic [2:0] dst, input logic [6:0] op);
		host.issue(CPID_RST, ea, rm, sp, dst, op);
		repeat (100) begin
			rd(A_STATUS);
			if (d[ST_BUSY] === 1'b0) break;
		end
	endtask
	// Main sequence.
	initial begin
		resetn = 1'b0;
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		rchk("cpid", A_CPID, 32'(CPID_RST), '1);
		rchk("status", A_STATUS, 32'h0, '1);
		rd(8'h34);
		chk("unmapped", 80'h1, {79'h0, e});
		wr(A_IRQ_MASK, 32'h3F);
		setfp(1, {16'h4006, 64'h89C0 << 48});
		run(6'h0, 1'b0, 3'd1, 3'd2, OP_INTRZ);
		chk("exc", 80'h02, {72'h0, d[15:8]});
		fpchk("trunc", 2, {16'h4006, 64'h89 << 56});
		fpchk("source", 1, {16'h4006, 64'h89C0 << 48});
		chk("irq", 80'h1, {79'h0, irq});
		rchk("irq status", A_IRQ_ST, 32'h11, '1);
		// The read clear lands with the access edge; look once it settled.
		@(negedge clk_sys);
		chk("irq", 80'h0, {79'h0, irq});
		setfp(3, {16'hC006, 64'h89C0 << 48});
		run(6'h0, 1'b0, 3'd3, 3'd3, OP_INTRZ);
		fpchk("same reg", 3, {16'hC006, 64'h89 << 56});
		for (int i = 0; i < 11; i++) begin
			setfp(5, SRC[i]);
			run(6'h0, 1'b0, 3'd5, 3'd6, i > 4 ? OP_LOG10 : OP_INTRZ);
			chk("exc", {72'h0, EXC[i]}, {72'h0, d[15:8]});
			fpchk("special", 6, RES[i]);
		end
		setfp(1, {16'h4005, 64'hC8 << 56});
		run(6'h0, 1'b0, 3'd1, 3'd2, OP_LOG10);
		// The truncated result lies just below two; its exponent is fixed.
		wr(A_REG_SEL, 32'h2);
		rd(A_REG_LO);
		v[31:0] = d;
		rd(A_REG_MID);
		v[63:32] = d;
		rd(A_REG_HI);
		v[79:64] = d[15:0];
		chk("log exp", {64'h0, 16'h3FFF}, {64'h0, v[79:64]});
		chk("log near 2", 80'h1, {79'h0, v == {16'h4000, K} ||
			v[79:56] == 24'h3FFF_FF});
		for (int f = 0; f < 7; f++) begin
			wr(A_OPND0, MEM[f][31:0]);
			wr(A_OPND1, MEM[f][63:32]);
			wr(A_OPND2, MEM[f][95:64]);
			run(f inside {2, 3, 5} ? 6'h3C : 6'h00, 1'b1, 3'(f), 3'd4,
				OP_INTRZ);
			fpchk("format", 4, P123 | {f == 0 || f == 6, 79'h0});
		end
		for (int r = 0; r < 5; r++) begin
			run({3'h7, 3'(r)}, 1'b1, FMT_L, 3'd4, OP_INTRZ);
			chk("ea class", {76'h0, CLS[r]}, {76'h0, d[3:0]});
		end
		rd(A_IRQ_ST);
		host.issue(3'h2, 6'h0, 1'b0, 3'd1, 3'd4, OP_INTRZ);
		rchk("foreign", A_IRQ_ST, 32'h0, '1);
		fpchk("foreign", 4, {16'h4006, 64'h85 << 56});
		run(6'h08, 1'b1, FMT_L, 3'd4, OP_LOG10);
		rchk("illegal", A_STATUS, 32'h40, 32'h40);
		rchk("illegal irq", A_IRQ_ST, 32'h20, 32'h21);
		run(6'h00, 1'b1, FMT_D, 3'd4, OP_LOG10);
		rchk("illegal", A_IRQ_ST, 32'h20, 32'h21);
		fpchk("kept", 4, {16'h4006, 64'h85 << 56});
		wr(A_STATUS, 32'h005A_0000);
		wr(A_IRQ_MASK, 32'h0);
		run(6'h0, 1'b0, 3'd1, 3'd2, OP_INTRZ);
		chk("quotient", 80'h5A, {72'h0, d[23:16]});
		chk("masked irq", 80'h0, {79'h0, irq});
		rchk("done", A_IRQ_ST, 32'h1, 32'h1);
		close_out();
	end
	// Cuts a hang short.
	initial begin
		repeat (60000) @(posedge clk_sys);
		error_cnt++;
		close_out();
	end
endmodule
